// ===== core/addr_decode_params.svh
`ifndef ADDR_DECODE_PARAMS_SVH
`define ADDR_DECODE_PARAMS_SVH
`define ADDR_W          24
`define DATA_W          16
`define REG_HI_PATTERN  3'h7
`define REG_WIN_LO      12'h000
`define REG_WIN_MSB     23
`define REG_WIN_LSB     20
`define SPACE_USER_DATA 3'h1
`define SPACE_USER_PROG 3'h2
`define SPACE_SUP_DATA  3'h5
`define SPACE_SUP_PROG  3'h6
`define RESET_VEC_ADDR  24'h000000
`define VBR_RESET       24'h000000
`endif

// ===== core/addr_decode_pkg.sv
`default_nettype none
package addr_decode_pkg;
  typedef enum logic [1:0] {
    TGT_NONE     = 2'h0,
    TGT_INTERNAL = 2'h1,
    TGT_EXTERNAL = 2'h2,
    TGT_REFUSED  = 2'h3
  } target_t;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_ACCESS = 3'h2,
    ST_VECTOR = 3'h4
  } state_t;
endpackage
`default_nettype wire

// ===== core/module_register_address_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "addr_decode_params.svh"
module module_register_address_decode
  import addr_decode_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Configuration
  input  wire logic              register_block_relocate,
  input  wire logic [ADDR_W-1:0] vector_table_base,
  // Processor request
  input  wire logic              req_valid,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              req_write,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              req_supervisor,
  input  wire logic              req_program,
  input  wire logic              req_vector,
  input  wire logic              req_reset_vector,
  input  wire logic [9:0]        req_vector_offset,
  // Internal module register map, combinational lookup on the offset
  output logic [11:0]            map_offset,
  input  wire logic              map_implemented,
  input  wire logic              map_reserved,
  input  wire logic              map_supervisor_only,
  // Decoded cycle
  output logic                   cyc_valid_ff,
  output logic [ADDR_W-1:0]      cyc_addr_ff,
  output logic                   cyc_write_ff,
  output logic [DATA_W-1:0]      cyc_wdata_ff,
  output logic [2:0]             access_space_code_ff,
  output logic                   cyc_internal_ff,
  output logic                   cyc_external_ff,
  output logic                   cyc_refused_ff
);
  state_t              state_ff;
  state_t              nxt_state;
  logic [ADDR_W-1:0]   nxt_addr;
  logic [2:0]          nxt_space;
  target_t             nxt_target;
  logic                in_window;

  function automatic logic [2:0] space_code(input logic sup, input logic prog);
    if (sup && prog) return `SPACE_SUP_PROG;
    else if (sup)    return `SPACE_SUP_DATA;
    else if (prog)   return `SPACE_USER_PROG;
    else             return `SPACE_USER_DATA;
  endfunction

  // Address and space formation
  always_comb begin
    nxt_addr  = req_addr;
    nxt_space = space_code(req_supervisor, req_program);
    if (req_vector) begin
      if (req_reset_vector) begin
        nxt_addr  = `RESET_VEC_ADDR;
        nxt_space = `SPACE_SUP_PROG;
      end else begin
        nxt_addr  = vector_table_base + ADDR_W'({req_vector_offset, 2'b00});
        nxt_space = `SPACE_SUP_DATA;
      end
    end
  end

  // Window match; the 4 KB block is the top 4 KB of the M111 megabyte
  assign in_window  = (nxt_addr[`REG_WIN_MSB:`REG_WIN_LSB] == {register_block_relocate, `REG_HI_PATTERN}) &&
                      (nxt_addr[19:12] == 8'hff);
  assign map_offset = nxt_addr[11:0];

  // Target selection; reserved wins so nothing leaks outside
  always_comb begin
    if (!in_window) begin
      nxt_target = TGT_EXTERNAL;
    end else if (map_reserved) begin
      nxt_target = TGT_NONE;
    end else if (!map_implemented) begin
      nxt_target = TGT_EXTERNAL;
    end else if (map_supervisor_only && !nxt_space[2]) begin
      nxt_target = TGT_REFUSED;
    end else begin
      nxt_target = TGT_INTERNAL;
    end
  end

  // Decode state mirrors the request kind; no state waits, so requests may run back to back
  always_comb begin
    nxt_state = ST_IDLE;
    case (state_ff)
      ST_IDLE, ST_ACCESS, ST_VECTOR: begin
        if (req_valid) begin
          nxt_state = req_vector ? ST_VECTOR : ST_ACCESS;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state_ff <= ST_IDLE;
    else         state_ff <= nxt_state;
  end

  // One cycle of registered decode latency; bus path is 24/16 bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_valid_ff         <= 1'b0;
      cyc_addr_ff          <= '0;
      cyc_write_ff         <= 1'b0;
      cyc_wdata_ff         <= '0;
      access_space_code_ff <= `SPACE_SUP_PROG;
      cyc_internal_ff      <= 1'b0;
      cyc_external_ff      <= 1'b0;
      cyc_refused_ff       <= 1'b0;
    end else begin
      cyc_valid_ff         <= req_valid;
      cyc_addr_ff          <= nxt_addr;
      cyc_write_ff         <= req_write && !req_vector;
      cyc_wdata_ff         <= req_wdata;
      access_space_code_ff <= nxt_space;
      cyc_internal_ff      <= req_valid && nxt_target == TGT_INTERNAL;
      cyc_external_ff      <= req_valid && nxt_target == TGT_EXTERNAL;
      cyc_refused_ff       <= req_valid && nxt_target == TGT_REFUSED;
    end
  end

  // Assertions
  a_reserved_stays_in: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && in_window && map_reserved) |=> !cyc_external_ff)
    else $error("reserved region forwarded externally");
  a_unused_goes_out: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && in_window && !map_reserved && !map_implemented) |=> cyc_external_ff)
    else $error("unused register address not forwarded");
  a_window_low_map: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector && !register_block_relocate && req_addr[23:12] == 12'h7ff && map_implemented &&
     !map_reserved && !map_supervisor_only) |=> cyc_internal_ff)
    else $error("low window not decoded");
  a_window_high_map: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector && register_block_relocate && req_addr[23:12] == 12'h7ff) |=> !cyc_internal_ff)
    else $error("window decoded at wrong relocation");
  a_user_refused: assert property (@(posedge clk) disable iff (!arst_n)
    cyc_internal_ff |-> access_space_code_ff[2] || !$past(map_supervisor_only))
    else $error("user access reached supervisor-only register");
  a_vector_sum: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && req_vector && !req_reset_vector) |=>
      cyc_addr_ff == $past(vector_table_base) + {$past(req_vector_offset), 2'b00})
    else $error("vector address not base plus offset");
  a_vector_space: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && req_vector) |=> access_space_code_ff == ($past(req_reset_vector) ? 3'h6 : 3'h5))
    else $error("vector fetch in wrong space");
  a_reset_fixed: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && req_reset_vector && req_vector) |=> cyc_addr_ff == 24'h000000)
    else $error("reset vector not at fixed location");
  a_space_code: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector && !req_supervisor && req_program) |=> access_space_code_ff == 3'h2)
    else $error("user program space code wrong");
  a_one_target: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot0({cyc_internal_ff, cyc_external_ff, cyc_refused_ff}))
    else $error("more than one target selected");

  // Window placement
  a_window_moved: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector && register_block_relocate && req_addr[23:12] == 12'hfff && map_implemented &&
     !map_reserved && !map_supervisor_only) |=> cyc_internal_ff)
    else $error("relocated window not decoded");
  a_outside_external: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !in_window) |=> cyc_external_ff)
    else $error("access outside the window not sent out");
  a_reserved_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && in_window && map_reserved) |=> cyc_valid_ff && !cyc_internal_ff && !cyc_refused_ff)
    else $error("reserved region given a target");

  // Bus path and latency
  a_valid_follows: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> cyc_valid_ff == $past(req_valid))
    else $error("cycle valid not one cycle after request");
  a_addr_passes: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector) |=> cyc_addr_ff == $past(req_addr) && cyc_wdata_ff == $past(req_wdata))
    else $error("address or data altered on the way");
  a_state_tracks: assert property (@(posedge clk) disable iff (!arst_n)
    cyc_valid_ff == (state_ff != ST_IDLE))
    else $error("cycle valid disagrees with decode state");
  a_flags_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !cyc_valid_ff |-> !(cyc_internal_ff || cyc_external_ff || cyc_refused_ff))
    else $error("target flag without a cycle");

  // Protection and vectors
  a_user_denied: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector && !req_supervisor && in_window && map_implemented && !map_reserved &&
     map_supervisor_only) |=> cyc_refused_ff)
    else $error("user access to supervisor-only register not refused");
  a_vector_reads: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == ST_VECTOR) |-> !cyc_write_ff && access_space_code_ff[2])
    else $error("vector fetch not a supervisor read");

  // Space codes
  a_user_data_code: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector && !req_supervisor && !req_program) |=> access_space_code_ff == 3'h1)
    else $error("user data space code wrong");
  a_sup_data_code: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector && req_supervisor && !req_program) |=> access_space_code_ff == 3'h5)
    else $error("supervisor data space code wrong");
  a_sup_prog_code: assert property (@(posedge clk) disable iff (!arst_n)
    (req_valid && !req_vector && req_supervisor && req_program) |=> access_space_code_ff == 3'h6)
    else $error("supervisor program space code wrong");
endmodule
`default_nettype wire

// ===== test/reg_map_model.sv
`timescale 1ns/1ps
`default_nettype none
module reg_map_model (
  // Lookup
  input  wire logic [11:0] map_offset,
  // Answers
  output logic             map_implemented,
  output logic             map_reserved,
  output logic             map_supervisor_only,
  // External decoding of forwarded cycles
  input  wire logic        cyc_external_ff,
  input  wire logic [2:0]  access_space_code_ff,
  output logic             ext_sel_single,
  output logic             ext_sel_split_sup,
  output logic             ext_full_valid,
  output logic [1:0]       ext_space_full
);
  // 000-0ff implemented, low half supervisor-only; 100-1ff reserved; rest unused
  assign map_implemented     = (map_offset[11:8] == 4'h0);
  assign map_reserved        = (map_offset[11:8] == 4'h1);
  assign map_supervisor_only = map_implemented && !map_offset[7];
  // Single space leaves every code line undecoded
  assign ext_sel_single      = cyc_external_ff;
  assign ext_sel_split_sup   = cyc_external_ff && access_space_code_ff[2];
  // Four spaces need all three lines; index is supervisor, program
  assign ext_full_valid      = cyc_external_ff && (access_space_code_ff[1] ^ access_space_code_ff[0]);
  assign ext_space_full      = access_space_code_ff[2:1];
endmodule
`default_nettype wire

// ===== test/test_module_register_address_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "addr_decode_params.svh"
module test_module_register_address_decode;
  logic        clk, arst_n, register_block_relocate, req_valid, req_write, req_supervisor;
  logic        req_program, req_vector, req_reset_vector, cyc_valid_ff, cyc_write_ff;
  logic        cyc_internal_ff, cyc_external_ff, cyc_refused_ff;
  logic        map_implemented, map_reserved, map_supervisor_only;
  logic        ext_sel_single, ext_sel_split_sup, ext_full_valid;
  logic [1:0]  ext_space_full;
  logic [23:0] vector_table_base, req_addr, cyc_addr_ff;
  logic [15:0] req_wdata, cyc_wdata_ff;
  logic [9:0]  req_vector_offset;
  logic [11:0] map_offset;
  logic [2:0]  access_space_code_ff;
  int          mismatches, checks_done;
  module_register_address_decode DUT (
    .clk, .arst_n, .register_block_relocate, .vector_table_base, .req_valid, .req_addr, .req_write,
    .req_wdata, .req_supervisor, .req_program, .req_vector, .req_reset_vector, .req_vector_offset,
    .map_offset, .map_implemented, .map_reserved, .map_supervisor_only, .cyc_valid_ff, .cyc_addr_ff,
    .cyc_write_ff, .cyc_wdata_ff, .access_space_code_ff, .cyc_internal_ff, .cyc_external_ff, .cyc_refused_ff
  );
  reg_map_model map (.map_offset, .map_implemented, .map_reserved, .map_supervisor_only,
                     .cyc_external_ff, .access_space_code_ff, .ext_sel_single, .ext_sel_split_sup,
                     .ext_full_valid, .ext_space_full);
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic go(input logic [23:0] a, input logic s, p, ve, r, input logic [9:0] o,
                    input logic [23:0] ea, input logic [2:0] esp, input logic [2:0] tg);
    @(posedge clk);
    {req_valid, req_addr, req_supervisor, req_program, req_vector, req_reset_vector,
     req_vector_offset} <= {1'h1, a, s, p, ve, r, o};
    @(negedge clk);
    check(map_offset, ea[11:0]);
    @(posedge clk);
    req_valid <= 1'h0;
    @(negedge clk);
    check(cyc_valid_ff, 24'h1);
    check(cyc_addr_ff, ea);
    check(access_space_code_ff, esp);
    check({cyc_internal_ff, cyc_external_ff, cyc_refused_ff}, tg);
    check({cyc_write_ff, cyc_wdata_ff}, {req_write & !ve, 16'h5a3c});
    check(ext_sel_single, tg == 3'h2);
    check(ext_sel_split_sup, tg == 3'h2 && esp[2]);
    check({ext_full_valid, ext_space_full}, {tg == 3'h2, esp[2:1]});
    @(negedge clk);
    check({cyc_valid_ff, cyc_internal_ff, cyc_external_ff, cyc_refused_ff}, 24'h0);
  endtask
  task automatic sc_window(input logic m);
    logic [23:0] b;
    b = {m, 3'h7, 8'hff, 12'h090};
    @(posedge clk);
    register_block_relocate <= m;
    go(b, 1'h0, 1'h0, 1'h0, 1'h0, 10'h0, b, `SPACE_USER_DATA, 3'h4);
    go(b - 24'h1000, 1'h0, 1'h0, 1'h0, 1'h0, 10'h0, b - 24'h1000, `SPACE_USER_DATA, 3'h2);
    go(b ^ 24'h800000, 1'h0, 1'h0, 1'h0, 1'h0, 10'h0, b ^ 24'h800000, `SPACE_USER_DATA, 3'h2);
  endtask
  task automatic sc_holes;
    @(posedge clk);
    {register_block_relocate, req_write} <= 2'h0;
    go(24'h7ff200, 1'h1, 1'h0, 1'h0, 1'h0, 10'h0, 24'h7ff200, `SPACE_SUP_DATA, 3'h2);
    go(24'h7ff1fe, 1'h1, 1'h0, 1'h0, 1'h0, 10'h0, 24'h7ff1fe, `SPACE_SUP_DATA, 3'h0);
    @(posedge clk);
    req_write <= 1'h1;
  endtask
  task automatic sc_super;
    go(24'h7ff010, 1'h0, 1'h1, 1'h0, 1'h0, 10'h0, 24'h7ff010, `SPACE_USER_PROG, 3'h1);
    go(24'h7ff07e, 1'h1, 1'h1, 1'h0, 1'h0, 10'h0, 24'h7ff07e, `SPACE_SUP_PROG, 3'h4);
  endtask
  task automatic sc_vector;
    @(posedge clk);
    vector_table_base <= 24'h001000;
    go(24'h7ff010, 1'h0, 1'h0, 1'h1, 1'h0, 10'h3, 24'h00100c, `SPACE_SUP_DATA, 3'h2);
    @(posedge clk);
    vector_table_base <= 24'habc000;
    go(24'h0, 1'h1, 1'h1, 1'h1, 1'h0, 10'h3ff, 24'habcffc, `SPACE_SUP_DATA, 3'h2);
    go(24'h123456, 1'h0, 1'h0, 1'h1, 1'h1, 10'h5, `RESET_VEC_ADDR, `SPACE_SUP_PROG, 3'h2);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Far beyond the few dozen cycles the scenarios need
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    {arst_n, register_block_relocate, vector_table_base, req_valid, req_addr} = '0;
    {req_supervisor, req_program, req_vector, req_reset_vector, req_vector_offset} = '0;
    {req_write, req_wdata} = {1'h1, 16'h5a3c};
    repeat (12) @(posedge clk);
    check(access_space_code_ff, `SPACE_SUP_PROG);
    check({cyc_valid_ff, cyc_internal_ff, cyc_external_ff, cyc_refused_ff, cyc_addr_ff[19:0]}, 24'h0);
    arst_n <= 1'h1;
    sc_window(1'h0);
    sc_window(1'h1);
    sc_holes;
    sc_super;
    sc_vector;
    tally_and_finish;
  end
endmodule
`default_nettype wire
